/* File: logic/sonet_sdh_pointer_interpreter.sv */
// Receive payload pointer interpreter with its APB register slave.
`timescale 1ns/1ps
`include "ptr_interp_regs.svh"
module sonet_sdh_pointer_interpreter (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        pair_valid,
   input  wire logic        pair_first,
   input  wire logic [15:0] pair_word,
   input  wire logic        frame_end,
   output logic             interrupt_out_a,
   output logic             interrupt_out_b,
   output ptr_interp_pkg::ptr_state_t ptr_state
);
   import ptr_interp_pkg::*;

   // Register file.
   logic       sdh_mode_q;
   logic [1:0] mask_a_q;
   logic [1:0] mask_b_q;
   logic [31:0] rdata_q;

   // Frame collection.
   logic       got_first_q;
   logic [7:0] pair_idx_q;
   logic       p_normal_state_q;
   logic       p_ndf_q;
   logic       p_ais_q;
   logic       p_inc_q;
   logic       p_dec_q;
   logic [9:0] p_val_q;
   logic       all_ci_normal_state_q;
   logic       all_ci_ais_q;

   // Interpreter state.
   ptr_state_t state_q;
   logic [9:0] accepted_q;
   logic       acc_valid_q;
   logic [9:0] cand_q;
   logic [1:0] normal_state_run_q;
   logic [1:0] ais_run_q;
   logic [3:0] inv_run_q;
   logic [1:0] hold_q;

   // Classifier outputs.
   logic c_normal_state;
   logic c_ndf;
   logic c_ais;
   logic c_inc;
   logic c_dec;
   logic c_ci_normal_state;
   logic c_ci_ais;

   // Frame decision terms.
   logic       f_normal_state;
   logic       f_ndf;
   logic       f_ais;
   logic       f_inc;
   logic       f_dec;
   logic       same_cand;
   logic       go_normal_state;
   logic       go_ais;
   logic       go_lop;
   logic       valid_ptr;
   logic [7:0] pair_limit;

   // Bus decode.
   logic       wr_en;
   logic       rd_en;
   logic       mapped;
   logic       rd_alarm;
   logic       rd_pend;
   logic       ais_latch;
   logic       lop_latch;
   logic       ais_pend;
   logic       lop_pend;
   logic       in_ais;
   logic       in_lop;

   ptr_word_classifier u_cls (
      .word     (pair_word),
      .sdh_mode (sdh_mode_q),
      .accepted (accepted_q),
      .is_normal_state  (c_normal_state),
      .is_ndf   (c_ndf),
      .is_ais   (c_ais),
      .is_inc   (c_inc),
      .is_dec   (c_dec),
      .ci_normal_state  (c_ci_normal_state),
      .ci_ais   (c_ci_ais)
   );

   // APB decode; the slave never inserts wait states.
   assign wr_en    = psel && penable && pwrite;
   assign rd_en    = psel && penable && !pwrite;
   assign pready   = 1'b1;
   assign mapped   = (paddr == `OFS_CTRL) || (paddr == `OFS_ALARM) ||
                     (paddr == `OFS_PEND) || (paddr == `OFS_MASK_A) ||
                     (paddr == `OFS_MASK_B) || (paddr == `OFS_STATE);
   assign pslverr  = psel && penable && !mapped;
   assign rd_alarm = rd_en && (paddr == `OFS_ALARM);
   assign rd_pend  = rd_en && (paddr == `OFS_PEND);
   assign prdata   = rdata_q;

   // Software-written control: mode and the two mask sets.
   always_ff @(posedge mclk) begin
      if (rst) begin
         sdh_mode_q <= `CTRL_RESET;
         mask_a_q   <= `MASK_RESET;
         mask_b_q   <= `MASK_RESET;
      end else if (wr_en) begin
         if (paddr == `OFS_CTRL) begin
            sdh_mode_q <= pwdata[0];
         end
         if (paddr == `OFS_MASK_A) begin
            mask_a_q <= pwdata[1:0];
         end
         if (paddr == `OFS_MASK_B) begin
            mask_b_q <= pwdata[1:0];
         end
      end
   end

   // Read data is caught in the setup cycle, so the clear-on-read
   // at the access edge cannot change what is returned.
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (psel && !penable) begin
         case (paddr)
            `OFS_CTRL:   rdata_q <= {31'h0000_0000, sdh_mode_q};
            `OFS_ALARM:  rdata_q <= {30'h0000_0000, lop_latch, ais_latch};
            `OFS_PEND:   rdata_q <= {30'h0000_0000, lop_pend, ais_pend};
            `OFS_MASK_A: rdata_q <= {30'h0000_0000, mask_a_q};
            `OFS_MASK_B: rdata_q <= {30'h0000_0000, mask_b_q};
            `OFS_STATE:  rdata_q <= {5'h00, acc_valid_q, accepted_q,
                                     14'h0000, in_ais, in_lop};
            default:     rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // SONET checks every pair, SDH only the first AU-4.
   assign pair_limit = sdh_mode_q ? `PAIRS_SDH : `PAIRS_SONET;

   // Primary pair capture and later-pair concatenation check.
   always_ff @(posedge mclk) begin
      if (rst) begin
         got_first_q   <= 1'b0;
         pair_idx_q    <= 8'h00;
         p_normal_state_q      <= 1'b0;
         p_ndf_q       <= 1'b0;
         p_ais_q       <= 1'b0;
         p_inc_q       <= 1'b0;
         p_dec_q       <= 1'b0;
         p_val_q       <= 10'h000;
         all_ci_normal_state_q <= 1'b1;
         all_ci_ais_q  <= 1'b1;
      end else if (pair_valid && pair_first) begin
         got_first_q   <= 1'b1;
         pair_idx_q    <= 8'h01;
         p_normal_state_q      <= c_normal_state;
         p_ndf_q       <= c_ndf;
         p_ais_q       <= c_ais;
         p_inc_q       <= c_inc && acc_valid_q;
         p_dec_q       <= c_dec && acc_valid_q;
         p_val_q       <= pair_word[9:0];
         all_ci_normal_state_q <= 1'b1;
         all_ci_ais_q  <= 1'b1;
      end else if (pair_valid && pair_idx_q < pair_limit) begin
         pair_idx_q    <= pair_idx_q + 8'h01;
         all_ci_normal_state_q <= all_ci_normal_state_q && c_ci_normal_state;
         all_ci_ais_q  <= all_ci_ais_q && c_ci_ais;
      end else if (frame_end) begin
         got_first_q <= 1'b0;
      end
   end

   // Whole-frame verdicts; a bad concatenation spoils the frame.
   assign f_normal_state = got_first_q && p_normal_state_q && all_ci_normal_state_q;
   assign f_ndf  = got_first_q && p_ndf_q && all_ci_normal_state_q;
   assign f_ais  = got_first_q && p_ais_q && all_ci_ais_q;
   assign f_inc  = got_first_q && p_inc_q && all_ci_normal_state_q &&
                   state_q == ST_NORMAL && hold_q == 2'h0;
   assign f_dec  = got_first_q && p_dec_q && all_ci_normal_state_q &&
                   state_q == ST_NORMAL && hold_q == 2'h0 && !f_inc;
   assign same_cand = f_normal_state && (p_val_q == cand_q);

   // Persistence outcomes; three equal normals outrank everything.
   assign go_normal_state = same_cand && (normal_state_run_q == `NORMAL_STATE_PERSIST - 2'h1);
   assign go_ais  = f_ais && (ais_run_q == `AIS_PERSIST - 2'h1) &&
                    state_q != ST_AIS;

   // What counts as a valid pointer depends on the state.
   always_comb begin
      case (state_q)
         ST_AIS:    valid_ptr = f_ais;
         ST_NORMAL: valid_ptr = f_ndf || f_inc || f_dec ||
                                (f_normal_state && p_val_q == accepted_q);
         default:   valid_ptr = 1'b0;
      endcase
   end
   assign go_lop = !valid_ptr && state_q != ST_LOP &&
                   inv_run_q == `LOP_PERSIST - 4'h1;

   // Frame counters step only at frame end.
   always_ff @(posedge mclk) begin
      if (rst) begin
         cand_q     <= 10'h000;
         normal_state_run_q <= 2'h0;
         ais_run_q  <= 2'h0;
         inv_run_q  <= 4'h0;
      end else if (frame_end) begin
         cand_q <= p_val_q;
         if (!f_normal_state) begin
            normal_state_run_q <= 2'h0;
         end else if (!same_cand) begin
            normal_state_run_q <= 2'h1;
         end else if (normal_state_run_q != `NORMAL_STATE_PERSIST) begin
            normal_state_run_q <= normal_state_run_q + 2'h1;
         end
         if (!f_ais) begin
            ais_run_q <= 2'h0;
         end else if (ais_run_q != `AIS_PERSIST) begin
            ais_run_q <= ais_run_q + 2'h1;
         end
         if (valid_ptr || go_normal_state || go_ais || go_lop) begin
            inv_run_q <= 4'h0;
         end else if (inv_run_q != `LOP_PERSIST) begin
            inv_run_q <= inv_run_q + 4'h1;
         end
      end
   end

   // State machine and accepted pointer.
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q     <= ST_LOP;
         accepted_q  <= 10'h000;
         acc_valid_q <= 1'b0;
      end else if (frame_end) begin
         if (go_normal_state) begin
            state_q     <= ST_NORMAL;
            accepted_q  <= p_val_q;
            acc_valid_q <= 1'b1;
         end else if (go_ais) begin
            state_q     <= ST_AIS;
            acc_valid_q <= 1'b0;
         end else if (go_lop) begin
            state_q     <= ST_LOP;
            acc_valid_q <= 1'b0;
         end else if (state_q == ST_NORMAL && f_ndf) begin
            accepted_q <= p_val_q;
         end else if (f_inc) begin
            accepted_q <= (accepted_q == `VALUE_MAX) ? 10'h000 :
                          accepted_q + 10'h001;
         end else if (f_dec) begin
            accepted_q <= (accepted_q == 10'h000) ? `VALUE_MAX :
                          accepted_q - 10'h001;
         end
      end
   end

   // Hold-off after any justification or new data flag.
   always_ff @(posedge mclk) begin
      if (rst) begin
         hold_q <= 2'h0;
      end else if (frame_end) begin
         if (!go_normal_state && !go_ais && !go_lop &&
             ((state_q == ST_NORMAL && f_ndf) || f_inc || f_dec)) begin
            hold_q <= `ADJ_HOLD;
         end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
         end
      end
   end

   assign in_ais    = state_q == ST_AIS;
   assign in_lop    = state_q == ST_LOP;
   assign ptr_state = state_q;

   // AIS starts clear; the loss alarm below starts at one, as loss is the reset state.
   latch_high_alarm #(.STATUS_RESET(1'b0)) u_ais_alarm (
      .mclk        (mclk),
      .rst         (rst),
      .status      (in_ais),
      .rd_latch    (rd_alarm),
      .rd_pend     (rd_pend),
      .latch_value (ais_latch),
      .pending     (ais_pend)
   );

   latch_high_alarm #(.STATUS_RESET(1'b1)) u_lop_alarm (
      .mclk        (mclk),
      .rst         (rst),
      .status      (in_lop),
      .rd_latch    (rd_alarm),
      .rd_pend     (rd_pend),
      .latch_value (lop_latch),
      .pending     (lop_pend)
   );

   // Interrupt outputs, registered from pending bits and masks.
   always_ff @(posedge mclk) begin
      if (rst) begin
         interrupt_out_a <= 1'b0;
         interrupt_out_b <= 1'b0;
      end else begin
         interrupt_out_a <= (ais_pend & mask_a_q[0]) | (lop_pend & mask_a_q[1]);
         interrupt_out_b <= (ais_pend & mask_b_q[0]) | (lop_pend & mask_b_q[1]);
      end
   end

   chk_reset_lop: assert property (@(posedge mclk)
      rst |=> state_q == ST_LOP && !acc_valid_q)
      else $error("reset did not give loss of pointer");
   chk_normal_state_accept: assert property (@(posedge mclk) disable iff (rst)
      frame_end && same_cand && normal_state_run_q == 2'h2
      |=> state_q == ST_NORMAL && accepted_q == $past(p_val_q))
      else $error("three equal normals not accepted");
   chk_ais_entry: assert property (@(posedge mclk) disable iff (rst)
      frame_end && f_ais && ais_run_q == 2'h2 && !same_cand
      |=> state_q == ST_AIS)
      else $error("three AIS pointers did not give AIS");
   chk_lop_entry: assert property (@(posedge mclk) disable iff (rst)
      frame_end && state_q != ST_LOP && !valid_ptr && inv_run_q == 4'h7 &&
      !go_normal_state && !go_ais |=> state_q == ST_LOP)
      else $error("eight invalid frames did not give loss");
   chk_adj_spacing: assert property (@(posedge mclk) disable iff (rst)
      frame_end && (f_inc || f_dec) && !go_normal_state |=> hold_q == `ADJ_HOLD)
      else $error("adjustment did not start the hold-off");
   chk_ndf_replace: assert property (@(posedge mclk) disable iff (rst)
      frame_end && state_q == ST_NORMAL && f_ndf && !go_ais && !go_lop
      |=> state_q == ST_NORMAL && accepted_q == $past(p_val_q))
      else $error("new data flag not taken");
   chk_sdh_size: assert property (@(posedge mclk) disable iff (rst)
      sdh_mode_q && pair_word[11:10] != 2'b10 |-> !c_normal_state && !c_ndf)
      else $error("size bits ignored in SDH mode");
   chk_irq_a_path: assert property (@(posedge mclk) disable iff (rst)
      $rose(ais_pend) && mask_a_q[0] && !wr_en |=> interrupt_out_a)
      else $error("masked-in pending did not raise interrupt A");
   chk_inc_step: assert property (@(posedge mclk) disable iff (rst)
      frame_end && f_inc && !go_normal_state && accepted_q != 10'h30E
      |=> accepted_q == $past(accepted_q) + 10'h001)
      else $error("increment did not advance pointer");
endmodule

/* File: logic/ptr_interp_regs.svh */
// Constants, register map and timing counts of the receive pointer interpreter.
// What this block does
// - Pointer word is H1 high, H2 low: flags 15-12, size 11-10, value 9-0.
// - SDH mode requires size bits 10, otherwise pointer invalid; SONET ignores them.
// - Mode bit selects SONET (192 pairs checked) or SDH (first 64 pairs).
// - Normal pointer: three of four flags match 0110, value 0 to 782.
// - New data flag: three of four flags match 1001, value 0 to 782.
// - AIS pointer: flags 1111, size bits 11, value all ones.
// - Increment inverts accepted I bits, decrement inverts D bits, normal flags.
// - Size bits checked in SDH, ignored in SONET, for all non-AIS types.
// - Later pairs are normal concatenation, AIS concatenation, or invalid.
// - No increment or decrement for three frames after any adjustment or new data.
// - SONET: increment or decrement needs eight of ten bits matching.
// - SDH: three inverted I and at most two D; both three means none.
// - Machine has three states: normal, loss of pointer, AIS.
// - In normal, one in-range new data flag replaces accepted value immediately.
// - Three equal in-range normal pointers from any state give normal, accept value.
// - Three AIS pointers from normal or loss give AIS; in AIS only AIS valid.
// - Eight consecutive invalid pointers move normal or AIS to loss of pointer.
// - In normal, valid increment or decrement moves accepted value by one.
// - In normal, a normal pointer equal to accepted value counts valid.
// - AIS entry or exit sets latch-high alarm: event read, then status.
// - AIS pending stays until read; drives interrupt A or B through masks.
// - Loss entry or exit sets latch-high alarm: event read, then status.
// - Loss pending stays until read; drives interrupt A or B through masks.
`ifndef PTR_INTERP_REGS_SVH
`define PTR_INTERP_REGS_SVH

`define OFS_CTRL     12'h000
`define OFS_ALARM    12'h004
`define OFS_PEND     12'h008
`define OFS_MASK_A   12'h00C
`define OFS_MASK_B   12'h010
`define OFS_STATE    12'h014

`define CTRL_RESET   1'b0
`define MASK_RESET   2'b00

`define FLAG_NORMAL  4'h6
`define FLAG_NDF     4'h9
`define FLAG_AIS     4'hF
`define SS_SDH       2'b10
`define SS_AIS       2'b11
`define VALUE_ONES   10'h3FF
`define VALUE_MAX    10'h30E
`define I_MASK       10'h2AA
`define D_MASK       10'h155

`define PAIRS_SONET  8'hC0
`define PAIRS_SDH    8'h40

`define NORMAL_STATE_PERSIST 2'h3
`define AIS_PERSIST  2'h3
`define LOP_PERSIST  4'h8
`define ADJ_HOLD     2'h3

`endif

/* File: logic/ptr_interp_pkg.sv */
// Types shared by the pointer interpreter files.
package ptr_interp_pkg;
   typedef enum logic [1:0] {
      ST_NORMAL,
      ST_LOP,
      ST_AIS
   } ptr_state_t;
endpackage

/* File: logic/ptr_word_classifier.sv */
// Combinational classification of one received H1/H2 pointer word.
`timescale 1ns/1ps
`include "ptr_interp_regs.svh"
module ptr_word_classifier (
   input  wire logic [15:0] word,
   input  wire logic        sdh_mode,
   input  wire logic [9:0]  accepted,
   output logic             is_normal_state,
   output logic             is_ndf,
   output logic             is_ais,
   output logic             is_inc,
   output logic             is_dec,
   output logic             ci_normal_state,
   output logic             ci_ais
);
   logic [3:0] flags;
   logic [1:0] ss;
   logic [9:0] val;
   logic [9:0] diff;
   logic       maj_normal_state;
   logic       maj_ndf;
   logic       ss_ok;
   logic       in_range;
   logic [3:0] inv_i;
   logic [3:0] inv_d;

   function automatic logic [3:0] ones10(input logic [9:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int k = 0; k < 10; k++) begin
         n = n + {3'b000, v[k]};
      end
      return n;
   endfunction

   // Field split of the word.
   assign flags = word[15:12];
   assign ss    = word[11:10];
   assign val   = word[9:0];
   assign diff  = val ^ accepted;

   // Three of four flag bits are enough, so one corrupted bit is tolerated.
   assign maj_normal_state = ones10({6'h00, ~(flags ^ `FLAG_NORMAL)}) >= 4'h3;
   assign maj_ndf  = ones10({6'h00, ~(flags ^ `FLAG_NDF)}) >= 4'h3;
   assign ss_ok    = !sdh_mode || (ss == `SS_SDH);
   assign in_range = val <= `VALUE_MAX;
   assign inv_i    = ones10(diff & `I_MASK);
   assign inv_d    = ones10(diff & `D_MASK);

   // Pointer types of the primary pair.
   assign is_normal_state = maj_normal_state && in_range && ss_ok;
   assign is_ndf  = maj_ndf && in_range && ss_ok;
   assign is_ais  = (flags == `FLAG_AIS) && (ss == `SS_AIS) && (val == `VALUE_ONES);

   // Justification; SONET allows two stray bits, SDH votes per bit group.
   always_comb begin
      if (sdh_mode) begin
         is_inc = (inv_i >= 4'h3) && (inv_d <= 4'h2);
         is_dec = (inv_d >= 4'h3) && (inv_i <= 4'h2);
      end else begin
         is_inc = ones10(diff ^ `I_MASK) <= 4'h2;
         is_dec = ones10(diff ^ `D_MASK) <= 4'h2;
      end
      is_inc = is_inc && maj_normal_state && ss_ok;
      is_dec = is_dec && maj_normal_state && ss_ok;
   end

   // Concatenation indicators of the later pairs.
   assign ci_normal_state = maj_normal_state && ss_ok && (val == `VALUE_ONES);
   assign ci_ais  = is_ais;
endmodule

/* File: logic/latch_high_alarm.sv */
// Latch-high alarm bit with a separate pending bit, both cleared by reading.
`timescale 1ns/1ps
module latch_high_alarm #(
   parameter logic STATUS_RESET = 1'b0
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic status,
   input  wire logic rd_latch,
   input  wire logic rd_pend,
   output logic      latch_value,
   output logic      pending
);
   logic prev_q;
   logic event_q;
   logic change;

   assign change = status != prev_q;

   // Previous status, to see every entry and every exit.
   always_ff @(posedge mclk) begin
      if (rst) begin
         prev_q <= STATUS_RESET;
      end else begin
         prev_q <= status;
      end
   end

   // Event memory; a change in the read cycle survives the read.
   always_ff @(posedge mclk) begin
      if (rst) begin
         event_q <= 1'b0;
      end else begin
         event_q <= change | (event_q & ~rd_latch);
      end
   end

   // Pending bit, same set-wins policy.
   always_ff @(posedge mclk) begin
      if (rst) begin
         pending <= 1'b0;
      end else begin
         pending <= change | (pending & ~rd_pend);
      end
   end

   // First read shows the event, the next one the live status.
   assign latch_value = event_q | status;

   chk_change_latched: assert property (@(posedge mclk) disable iff (rst)
      change && !rd_latch |=> latch_value && pending)
      else $error("alarm change not latched");
   chk_pend_holds: assert property (@(posedge mclk) disable iff (rst)
      pending && !rd_pend |=> pending)
      else $error("pending bit dropped without read");
endmodule

/* File: testbench/far_framer_model.sv */
// Far-end framer model that hands over H1/H2 pairs and frame ends.
`timescale 1ns/1ps
module far_framer_model (
   input  wire logic   mclk,
   output logic        pair_valid,
   output logic        pair_first,
   output logic [15:0] pair_word,
   output logic        frame_end
);
   initial begin
      pair_valid = 1'b0;
      pair_first = 1'b0;
      pair_word  = 16'h0000;
      frame_end  = 1'b0;
   end
   // One frame: the primary word first, then concatenation words, then the frame end.
   task automatic send_frame(input logic [15:0] primary, input logic [15:0] conc, input int pairs);
      for (int i = 0; i < pairs; i++) begin
         @(posedge mclk);
         pair_valid <= 1'b1;
         pair_first <= (i == 0);
         pair_word  <= (i == 0) ? primary : conc;
      end
      @(posedge mclk);
      pair_valid <= 1'b0;
      pair_first <= 1'b0;
      // The word is inverted once invalid, so a stale value can never look fresh.
      pair_word  <= ~pair_word;
      frame_end  <= 1'b1;
      @(posedge mclk);
      frame_end  <= 1'b0;
   endtask
endmodule

/* File: testbench/sonet_sdh_pointer_interpreter_test.sv */
// Self-checking bench for the receive pointer interpreter.
`timescale 1ns/1ps
`include "ptr_interp_regs.svh"
module sonet_sdh_pointer_interpreter_test;
   import ptr_interp_pkg::*;
   logic        mclk    = 1'b0;
   logic        rst     = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, pv, pf, fe, ia, ib, er;
   logic [15:0] pw;
   ptr_state_t  st;
   int          bad_count = 0;
   int          checked   = 0;
   always #12.5 mclk = ~mclk;
   sonet_sdh_pointer_interpreter u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pair_valid(pv), .pair_first(pf), .pair_word(pw), .frame_end(fe),
      .interrupt_out_a(ia), .interrupt_out_b(ib), .ptr_state(st));
   far_framer_model u_far (.mclk(mclk), .pair_valid(pv), .pair_first(pf), .pair_word(pw), .frame_end(fe));
   // Prints the counts and the verdict; a hang ends here as well.
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic check_st(input ptr_state_t exp);
      checked++;
      if (st !== exp) begin
         bad_count++;
         $display("ERROR ptr_state expected %0d seen %0d", exp, st);
      end
   endtask
   // One APB transfer; waits for pready under a bound and samples at that edge.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         bad_count++;
         finish_test();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Sends n equal frames, AIS ones with AIS concatenation, then lets results settle.
   task automatic frames(input logic [15:0] w, input int n);
      repeat (n) u_far.send_frame(w, (w == 16'hFFFF) ? 16'hFFFF : 16'h6BFF, 3);
      repeat (5) @(posedge mclk);
   endtask
   task automatic chk_ptr(input logic [9:0] exp);
      apb(1'b0, `OFS_STATE, 32'h0000_0000);
      check("accepted", {21'h0, 1'b1, exp}, {21'h0, rd[26:16]});
   endtask
   task automatic t_reset();
      check_st(ST_LOP);
      apb(1'b0, `OFS_STATE, 32'h0000_0000);
      check("state_reg", 32'h0000_0001, rd);
      apb(1'b0, 12'h0FC, 32'h0000_0000);
      check("unmapped", 32'h0000_0001, {rd[30:0], er});
   endtask
   task automatic t_acquire();
      apb(1'b1, `OFS_MASK_A, 32'h0000_0002);
      frames(16'h620A, 2);
      check_st(ST_LOP);
      frames(16'h620A, 1);
      check_st(ST_NORMAL);
      chk_ptr(10'h20A);
      check("irqs", 32'h0000_0001, {30'h0, ib, ia});
      apb(1'b0, `OFS_ALARM, 32'h0000_0000);
      check("alarm_event", 32'h0000_0002, rd);
      apb(1'b0, `OFS_ALARM, 32'h0000_0000);
      check("alarm_status", 32'h0000_0000, rd);
      apb(1'b0, `OFS_PEND, 32'h0000_0000);
      check("pending", 32'h0000_0002, rd);
      repeat (3) @(posedge mclk);
      check("irqs_clear", 32'h0000_0000, {30'h0, ib, ia});
   endtask
   // Increment, a refused decrement inside the hold, then an allowed decrement.
   task automatic t_adjust();
      frames(16'h68A0, 1);
      chk_ptr(10'h20B);
      frames(16'h6B5E, 1);
      chk_ptr(10'h20B);
      frames(16'h620B, 2);
      // One stray bit on top of the inverted D bits still leaves nine of ten matching.
      frames(16'h6B5C, 1);
      chk_ptr(10'h20A);
      check_st(ST_NORMAL);
   endtask
   // New data flag, then size-bit refusal and majority increment in SDH mode.
   task automatic t_ndf_sdh();
      frames(16'h9864, 1);
      chk_ptr(10'h064);
      apb(1'b1, `OFS_CTRL, 32'h0000_0001);
      frames(16'h60C8, 3);
      chk_ptr(10'h064);
      frames(16'h6AC4, 1);
      chk_ptr(10'h065);
      frames(16'h6865, 3);
      frames(16'h6B95, 1);
      chk_ptr(10'h065);
   endtask
   task automatic t_ais_lop();
      apb(1'b1, `OFS_MASK_B, 32'h0000_0001);
      apb(1'b1, `OFS_MASK_A, 32'h0000_0003);
      frames(16'hFFFF, 2);
      check_st(ST_NORMAL);
      frames(16'hFFFF, 1);
      check_st(ST_AIS);
      check("irqs", 32'h0000_0003, {30'h0, ib, ia});
      apb(1'b0, `OFS_ALARM, 32'h0000_0000);
      check("ais_event", 32'h0000_0001, rd);
      apb(1'b0, `OFS_ALARM, 32'h0000_0000);
      check("ais_status", 32'h0000_0001, rd);
      apb(1'b0, `OFS_PEND, 32'h0000_0000);
      check("ais_pend", 32'h0000_0001, rd);
      frames(16'h0000, 7);
      check_st(ST_AIS);
      frames(16'h0000, 1);
      check_st(ST_LOP);
      apb(1'b0, `OFS_PEND, 32'h0000_0000);
      check("both_pend", 32'h0000_0003, rd);
   endtask
   // Bounds the whole run so a stuck handshake cannot hang it.
   initial begin
      repeat (40000) @(posedge mclk);
      bad_count++;
      finish_test();
   end
   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_acquire();
      t_adjust();
      t_ndf_sdh();
      t_ais_lop();
      finish_test();
   end
endmodule
